// ### fbsh_params.svh
`ifndef FBSH_PARAMS_SVH
`define FBSH_PARAMS_SVH
// Functional notes
// - while stop command is set, close all node connections and stop field traffic.
// - scanning-halted status follows the host stop command.
// - send command starts one explicit transaction, outcome on done and error bits.
// - show-first presents the lowest node holding a fault entry.
// - show-next advances to the next node holding a fault entry.
// - clear-faults erases every fault table entry except one reported in the clearing cycle.
// - response larger than rx allocation raises receive overrun.
// - offline summary set when any configured node is not on line.
// - tx or rx buffer outside host register space raises buffer error.
// - failed tx buffer read raises fetch error.
// - node address above range raises bad address error.
// - address checks run range, configured, on line; first failure flagged.
// - no timely response raises timeout error.
// - any other field error raises the catch-all error.
// - failed response write-back raises write-back error.
// - on-line map is 64 bits in four words, node 0 at bit 0.
// - on-line bit only while polled connection established and exchanging data.
// - fault word 0 holds node address low byte, fault code high byte.
// - send bit sampled periodically, then full explicit sequence ends in done.
// - any sequence error aborts, setting its error flag and done.
// - polled-time fault reports ms between polls as 16 bits in fault word 1.

// clock and derived timing
`define FBSH_CLK_MHZ 100
`define FBSH_POLL_MS 1
`define FBSH_POLL_CYCLES (`FBSH_POLL_MS * 1000 * `FBSH_CLK_MHZ)
`define FBSH_XM_TIMEOUT_MS 1000
// command bit positions
`define FBSH_CMD_STOP 0
`define FBSH_CMD_SEND 1
`define FBSH_CMD_FIRST 2
`define FBSH_CMD_NEXT 3
`define FBSH_CMD_CLEAR 4
// status bit positions
`define FBSH_ST_OFFLINE 0
`define FBSH_ST_HALTED 1
`define FBSH_ST_DONE 2
`define FBSH_ST_ERR_LO 3
`define FBSH_ST_ERR_HI 11
// node range and fault codes
`define FBSH_MAX_NODE 8'h3f
`define FBSH_FAULT_POLL_TIME 8'h01
`define FBSH_FIRST_REG 16'h0001
`endif

// ### fbsh_pkg.sv
package fbsh_pkg;

	// four buffer descriptor words loaded by the host
	typedef struct packed {
		logic [15:0] tx_buffer_start;
		logic [15:0] tx_buffer_length;
		logic [15:0] rx_buffer_start;
		logic [15:0] rx_buffer_allocation;
	} fbsh_desc_t;

	// explicit error flags, lowest field lands on status bit 3
	typedef struct packed {
		logic rx_writeback_error;
		logic rx_overrun_error;
		logic misc_link_error;
		logic transaction_timeout_error;
		logic node_offline_error;
		logic node_unconfigured_error;
		logic bad_node_address_error;
		logic tx_fetch_error;
		logic buffer_range_error;
	} fbsh_xm_err_t;

	typedef enum logic [3:0] {
		XM_IDLE, XM_CHECK, XM_FETCH, XM_ADDR, XM_SEND, XM_WAIT, XM_SIZE, XM_WRITE, XM_FINISH
	} fbsh_xm_state_t;

endpackage

// ### fbsh_host_if.sv
`timescale 1ns/1ns
`include "fbsh_params.svh"

module fbsh_host_if import fbsh_pkg::*; #(
	parameter int POLL_CYCLES = `FBSH_POLL_CYCLES,
	parameter int TIMEOUT_MS = `FBSH_XM_TIMEOUT_MS,
	parameter int TX_DEPTH = 64,
	parameter int RX_DEPTH = 64
) (
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	// host command and status words
	input wire logic [7:0] CMD_I,
	input wire fbsh_desc_t DESC_I,
	input wire logic [63:0] STROBE_BITS_I,
	input wire logic [15:0] PLC_REG_COUNT_I,
	output logic [15:0] STATUS_O,
	output logic [63:0] ONLINE_MAP_O,
	output logic [15:0] FAULT_WORD0_O,
	output logic [15:0] FAULT_WORD1_O,
	// backplane mail access to host registers
	output logic MAIL_REQ_O,
	output logic MAIL_WE_O,
	output logic [15:0] MAIL_ADDR_O,
	output logic [15:0] MAIL_WDATA_O,
	input wire logic MAIL_ACK_I,
	input wire logic MAIL_ERR_I,
	input wire logic [15:0] MAIL_RDATA_I,
	// field scanner side
	output logic SCAN_ENABLE_O,
	output logic [63:0] STROBE_BITS_O,
	input wire logic [63:0] NODE_CONFIGURED_I,
	input wire logic [63:0] POLL_ESTABLISHED_I,
	input wire logic [63:0] POLL_ACTIVE_I,
	// fault reports from the scanner
	input wire logic FAULT_LOG_I,
	input wire logic [5:0] FAULT_NODE_I,
	input wire logic [7:0] FAULT_CODE_I,
	input wire logic [15:0] FAULT_DATA_I,
	// explicit message exchange engine
	output logic XM_REQ_O,
	output logic [5:0] XM_NODE_O,
	output logic [15:0] XM_TX_BYTES_O,
	input wire logic [$clog2(TX_DEPTH)-1:0] XM_RD_IDX_I,
	output logic [15:0] XM_RD_DATA_O,
	input wire logic XM_RSP_VALID_I,
	input wire logic [15:0] XM_RSP_DATA_I,
	input wire logic XM_RSP_DONE_I,
	input wire logic [15:0] XM_RSP_BYTES_I,
	input wire logic XM_RSP_ERR_I
);

	localparam int TW = $clog2(TX_DEPTH);
	localparam int RW = $clog2(RX_DEPTH);

	// --------------------------------------------------
	// host pin synchronisers
	// --------------------------------------------------
	logic [7:0] cmd_s1, cmd_s2, cmd_prev;
	fbsh_desc_t desc_s1, desc_s2;
	logic [63:0] strobe_s1, strobe_s2;

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			cmd_s1 <= 8'h00;
			cmd_s2 <= 8'h00;
			cmd_prev <= 8'h00;
			desc_s1 <= '0;
			desc_s2 <= '0;
			strobe_s1 <= 64'h0;
			strobe_s2 <= 64'h0;
		end else begin
			cmd_s1 <= CMD_I;
			cmd_s2 <= cmd_s1;
			cmd_prev <= cmd_s2;
			desc_s1 <= DESC_I;
			desc_s2 <= desc_s1;
			strobe_s1 <= STROBE_BITS_I;
			strobe_s2 <= strobe_s1;
		end
	end

	wire halted = cmd_s2[`FBSH_CMD_STOP];
	wire first_edge = cmd_s2[`FBSH_CMD_FIRST] & ~cmd_prev[`FBSH_CMD_FIRST];
	wire next_edge = cmd_s2[`FBSH_CMD_NEXT] & ~cmd_prev[`FBSH_CMD_NEXT];
	wire clear_edge = cmd_s2[`FBSH_CMD_CLEAR] & ~cmd_prev[`FBSH_CMD_CLEAR];

	// --------------------------------------------------
	// scanning control and node status
	// --------------------------------------------------
	logic offline_any;

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			SCAN_ENABLE_O <= 1'b0;
			STROBE_BITS_O <= 64'h0;
			ONLINE_MAP_O <= 64'h0;
			offline_any <= 1'b0;
		end else begin
			SCAN_ENABLE_O <= ~halted;
			STROBE_BITS_O <= strobe_s2;
			ONLINE_MAP_O <= POLL_ESTABLISHED_I & POLL_ACTIVE_I;
			offline_any <= |(NODE_CONFIGURED_I & ~(POLL_ESTABLISHED_I & POLL_ACTIVE_I));
		end
	end

	// --------------------------------------------------
	// fault table
	// --------------------------------------------------
	logic [63:0] fault_valid;
	logic [7:0] fault_code [64];
	logic [15:0] fault_data [64];
	logic [5:0] cursor;

	// search wraps so show-next cycles through every faulted node
	function automatic logic [6:0] find_from(input logic [63:0] v, input logic [5:0] start);
		logic [6:0] r;
		logic [5:0] k;
		r = 7'h00;
		for (int i = 63; i >= 0; i--) begin
			k = start + 6'(i);
			if (v[k]) begin
				r = {1'b1, k};
			end
		end
		return r;
	endfunction

	wire [6:0] hit_first = find_from(fault_valid, 6'h00);
	wire [6:0] hit_next = find_from(fault_valid, cursor + 6'h01);

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			fault_valid <= 64'h0;
		end else begin
			for (int n = 0; n < 64; n++) begin
				// a report in the clearing cycle survives
				if (FAULT_LOG_I && FAULT_NODE_I == 6'(n)) begin
					fault_valid[n] <= 1'b1;
				end else if (clear_edge) begin
					fault_valid[n] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (FAULT_LOG_I) begin
			fault_code[FAULT_NODE_I] <= FAULT_CODE_I;
			fault_data[FAULT_NODE_I] <= FAULT_DATA_I;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			cursor <= 6'h00;
			FAULT_WORD0_O <= 16'h0000;
			FAULT_WORD1_O <= 16'h0000;
		end else if (clear_edge) begin
			FAULT_WORD0_O <= 16'h0000;
			FAULT_WORD1_O <= 16'h0000;
		end else if (first_edge && hit_first[6]) begin
			cursor <= hit_first[5:0];
			FAULT_WORD0_O <= {fault_code[hit_first[5:0]], 2'b00, hit_first[5:0]};
			FAULT_WORD1_O <= fault_data[hit_first[5:0]];
		end else if (next_edge && hit_next[6]) begin
			cursor <= hit_next[5:0];
			FAULT_WORD0_O <= {fault_code[hit_next[5:0]], 2'b00, hit_next[5:0]};
			FAULT_WORD1_O <= fault_data[hit_next[5:0]];
		end
	end

	// --------------------------------------------------
	// poll tick, one pulse per millisecond
	// --------------------------------------------------
	logic [$clog2(POLL_CYCLES+1)-1:0] tick_cnt;
	logic tick;

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == '0);
			if (tick_cnt == '0) begin
				tick_cnt <= ($clog2(POLL_CYCLES+1))'(POLL_CYCLES - 1);
			end else begin
				tick_cnt <= tick_cnt - 1'b1;
			end
		end
	end

	// --------------------------------------------------
	// explicit transaction sequencer
	// --------------------------------------------------
	fbsh_xm_state_t state;
	fbsh_xm_err_t err;
	logic done;
	logic armed;
	fbsh_desc_t desc;
	logic [15:0] tx_mem [TX_DEPTH];
	logic [15:0] rx_mem [RX_DEPTH];
	logic [15:0] word_idx;
	logic [15:0] rsp_bytes;
	logic [15:0] rsp_words;
	logic [15:0] time_ms;

	wire [16:0] tx_words = ({1'b0, desc.tx_buffer_length} + 17'h00001) >> 1;
	wire [16:0] rx_words = ({1'b0, desc.rx_buffer_allocation} + 17'h00001) >> 1;
	wire [16:0] tx_end = {1'b0, desc.tx_buffer_start} + tx_words - 17'h00001;
	wire [16:0] rx_end = {1'b0, desc.rx_buffer_start} + rx_words - 17'h00001;
	wire [7:0] target = tx_mem[0][7:0];
	wire [16:0] rsp_total = {1'b0, rsp_bytes} + 17'h00002;
	wire [15:0] wb_words = 16'(({1'b0, rsp_bytes} + 17'h00001) >> 1) + 16'h0001;

	assign MAIL_REQ_O = (state == XM_FETCH) || (state == XM_WRITE);
	assign MAIL_WE_O = (state == XM_WRITE);
	assign XM_REQ_O = (state == XM_SEND);

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			armed <= 1'b0;
		end else if (tick && !cmd_s2[`FBSH_CMD_SEND]) begin
			armed <= 1'b0;
		end else if (state == XM_IDLE && tick && cmd_s2[`FBSH_CMD_SEND]) begin
			armed <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (state == XM_FETCH && MAIL_ACK_I && !MAIL_ERR_I) begin
			tx_mem[word_idx[TW-1:0]] <= MAIL_RDATA_I;
		end
		if (state == XM_WAIT && XM_RSP_VALID_I && rsp_words < 16'(RX_DEPTH)) begin
			rx_mem[rsp_words[RW-1:0]] <= XM_RSP_DATA_I;
		end
		XM_RD_DATA_O <= tx_mem[XM_RD_IDX_I];
	end

	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			state <= XM_IDLE;
			err <= '0;
			done <= 1'b0;
			desc <= '0;
			word_idx <= 16'h0000;
			rsp_bytes <= 16'h0000;
			rsp_words <= 16'h0000;
			time_ms <= 16'h0000;
			MAIL_ADDR_O <= 16'h0000;
			MAIL_WDATA_O <= 16'h0000;
			XM_NODE_O <= 6'h00;
			XM_TX_BYTES_O <= 16'h0000;
		end else begin
			unique case (state)
				XM_IDLE: begin
					// only sampled on the poll tick, as the host scan is slow anyway
					if (tick && cmd_s2[`FBSH_CMD_SEND] && !armed) begin
						err <= '0;
						done <= 1'b0;
						desc <= desc_s2;
						state <= XM_CHECK;
					end
				end
				XM_CHECK: begin
					word_idx <= 16'h0000;
					MAIL_ADDR_O <= desc.tx_buffer_start;
					if (desc.tx_buffer_length == 16'h0000 || desc.tx_buffer_start < `FBSH_FIRST_REG ||
						desc.rx_buffer_start < `FBSH_FIRST_REG || tx_end > {1'b0, PLC_REG_COUNT_I} ||
						rx_end > {1'b0, PLC_REG_COUNT_I} || tx_words > 17'(TX_DEPTH)) begin
						err.buffer_range_error <= 1'b1;
						state <= XM_FINISH;
					end else begin
						state <= XM_FETCH;
					end
				end
				XM_FETCH: begin
					if (MAIL_ERR_I) begin
						err.tx_fetch_error <= 1'b1;
						state <= XM_FINISH;
					end else if (MAIL_ACK_I) begin
						word_idx <= word_idx + 16'h0001;
						MAIL_ADDR_O <= MAIL_ADDR_O + 16'h0001;
						if (17'(word_idx) + 17'h00001 == tx_words) begin
							state <= XM_ADDR;
						end
					end
				end
				XM_ADDR: begin
					if (target > `FBSH_MAX_NODE) begin
						err.bad_node_address_error <= 1'b1;
						state <= XM_FINISH;
					end else if (!NODE_CONFIGURED_I[target[5:0]]) begin
						err.node_unconfigured_error <= 1'b1;
						state <= XM_FINISH;
					end else if (!ONLINE_MAP_O[target[5:0]]) begin
						err.node_offline_error <= 1'b1;
						state <= XM_FINISH;
					end else if (halted) begin
						err.misc_link_error <= 1'b1;
						state <= XM_FINISH;
					end else begin
						XM_NODE_O <= target[5:0];
						XM_TX_BYTES_O <= desc.tx_buffer_length;
						state <= XM_SEND;
					end
				end
				XM_SEND: begin
					rsp_words <= 16'h0000;
					time_ms <= 16'h0000;
					state <= XM_WAIT;
				end
				XM_WAIT: begin
					if (tick) begin
						time_ms <= time_ms + 16'h0001;
					end
					if (XM_RSP_VALID_I) begin
						rsp_words <= rsp_words + 16'h0001;
					end
					if (XM_RSP_ERR_I || halted || (XM_RSP_VALID_I && rsp_words >= 16'(RX_DEPTH))) begin
						err.misc_link_error <= 1'b1;
						state <= XM_FINISH;
					end else if (XM_RSP_DONE_I) begin
						rsp_bytes <= XM_RSP_BYTES_I;
						state <= XM_SIZE;
					end else if (time_ms >= 16'(TIMEOUT_MS)) begin
						err.transaction_timeout_error <= 1'b1;
						state <= XM_FINISH;
					end
				end
				XM_SIZE: begin
					word_idx <= 16'h0000;
					MAIL_ADDR_O <= desc.rx_buffer_start;
					MAIL_WDATA_O <= rsp_bytes;
					if (rsp_total > {1'b0, desc.rx_buffer_allocation}) begin
						err.rx_overrun_error <= 1'b1;
						state <= XM_FINISH;
					end else if (wb_words - 16'h0001 > rsp_words) begin
						err.misc_link_error <= 1'b1;
						state <= XM_FINISH;
					end else begin
						state <= XM_WRITE;
					end
				end
				XM_WRITE: begin
					if (MAIL_ERR_I) begin
						err.rx_writeback_error <= 1'b1;
						state <= XM_FINISH;
					end else if (MAIL_ACK_I) begin
						word_idx <= word_idx + 16'h0001;
						MAIL_ADDR_O <= MAIL_ADDR_O + 16'h0001;
						MAIL_WDATA_O <= rx_mem[word_idx[RW-1:0]];
						if (word_idx + 16'h0001 == wb_words) begin
							state <= XM_FINISH;
						end
					end
				end
				XM_FINISH: begin
					done <= 1'b1;
					state <= XM_IDLE;
				end
			endcase
		end
	end

	// --------------------------------------------------
	// status word, reserved bits read zero
	// --------------------------------------------------
	always_comb begin
		STATUS_O = 16'h0000;
		STATUS_O[`FBSH_ST_OFFLINE] = offline_any;
		STATUS_O[`FBSH_ST_HALTED] = halted;
		STATUS_O[`FBSH_ST_DONE] = done;
		// flags shown only with done, else a flag leads done by one cycle
		STATUS_O[`FBSH_ST_ERR_HI:`FBSH_ST_ERR_LO] = err & {$bits(err){done}};
	end

endmodule

// ### fbsh_assertions.sv
`timescale 1ns/1ns
// ----
// host interface checks
// ----
module fbsh_assertions import fbsh_pkg::*; (
	// watched ports
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] CMD_I,
	input wire logic [15:0] STATUS_O,
	input wire logic [63:0] ONLINE_MAP_O,
	input wire logic SCAN_ENABLE_O,
	input wire logic MAIL_REQ_O,
	input wire logic MAIL_WE_O,
	input wire logic [15:0] MAIL_ADDR_O,
	input wire logic MAIL_ACK_I,
	input wire logic MAIL_ERR_I,
	input wire logic XM_REQ_O,
	input wire logic [5:0] XM_NODE_O,
	input wire logic [63:0] NODE_CONFIGURED_I,
	input wire logic [63:0] POLL_ESTABLISHED_I,
	input wire logic [63:0] POLL_ACTIVE_I
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (!RST_N_I);
	logic [63:0] onl;
	assign onl = POLL_ESTABLISHED_I & POLL_ACTIVE_I;
	property p_halt_on;
		CMD_I[0] [*3] |-> STATUS_O[1];
	endproperty
	a_halt_on: assert property (p_halt_on) else $error("halted flag low");
	property p_halt_off;
		!CMD_I[0] [*3] |-> !STATUS_O[1];
	endproperty
	a_halt_off: assert property (p_halt_off) else $error("halted flag high");
	property p_stop;
		CMD_I[0] [*5] |-> !SCAN_ENABLE_O && !XM_REQ_O;
	endproperty
	a_stop: assert property (p_stop) else $error("field traffic while stopped");
	property p_offline;
		(|(NODE_CONFIGURED_I & ~onl)) [*4] |-> STATUS_O[0];
	endproperty
	a_offline: assert property (p_offline) else $error("offline summary low");
	// map is registered one cycle behind the poll inputs, so wait six cycles
	property p_online;
		(!CMD_I[0] && $stable(onl)) [*6] |-> ONLINE_MAP_O == onl;
	endproperty
	a_online: assert property (p_online) else $error("online map wrong");
	property p_err_done;
		|STATUS_O[11:3] |-> STATUS_O[2] && $onehot(STATUS_O[11:3]);
	endproperty
	a_err_done: assert property (p_err_done) else $error("error without done");
	property p_start_clear;
		$rose(MAIL_REQ_O) && !MAIL_WE_O |-> STATUS_O[11:2] == 10'h000;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("stale status");
	property p_addr_ok;
		XM_REQ_O |-> NODE_CONFIGURED_I[XM_NODE_O] && ONLINE_MAP_O[XM_NODE_O] && !STATUS_O[1];
	endproperty
	a_addr_ok: assert property (p_addr_ok) else $error("send to bad node");
	property p_one_send;
		XM_REQ_O |=> !XM_REQ_O ##1 !XM_REQ_O;
	endproperty
	a_one_send: assert property (p_one_send) else $error("repeated send");
	property p_mail_hold;
		MAIL_REQ_O && !MAIL_ACK_I && !MAIL_ERR_I |=> MAIL_REQ_O && $stable(MAIL_ADDR_O) && $stable(MAIL_WE_O);
	endproperty
	a_mail_hold: assert property (p_mail_hold) else $error("mail request dropped");
	c_done: cover property ($rose(STATUS_O[2]));
	c_send: cover property (XM_REQ_O);
	c_halt: cover property ($rose(STATUS_O[1]));
endmodule

bind fbsh_host_if fbsh_assertions chk (.*);

// ### fbsh_plc_model.sv
`timescale 1ns/1ns
// ----
// host register store behind mail access
// ----
module fbsh_plc_model (
	// mail request
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	// answer shaping
	input wire logic [1:0] lat_i,
	input wire logic fail_i,
	// mail answer
	output logic ack_o,
	output logic err_o,
	output logic [15:0] rdata_o
);
	logic [15:0] mem [0:255];
	logic [1:0] cnt = 2'h0;
	initial begin
		ack_o = 1'b0;
		err_o = 1'b0;
		rdata_o = 16'h0000;
	end
	// read data scrambled outside ack so stale data is never taken
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		err_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (!req_i || ack_o || err_o)
			cnt <= 2'h0;
		else if (cnt != lat_i)
			cnt <= cnt + 2'h1;
		else if (fail_i)
			err_o <= 1'b1;
		else begin
			ack_o <= 1'b1;
			if (we_i)
				mem[addr_i[7:0]] <= wdata_i;
			else
				rdata_o <= mem[addr_i[7:0]];
		end
	end
endmodule

// ### fbsh_host_if_test.sv
`timescale 1ns/1ns
module fbsh_host_if_test import fbsh_pkg::*;;
	logic CLOCK_I, RST_N_I, MAIL_REQ_O, MAIL_WE_O, MAIL_ACK_I, MAIL_ERR_I, SCAN_ENABLE_O, FAULT_LOG_I, XM_REQ_O;
	logic XM_RSP_VALID_I, XM_RSP_DONE_I, XM_RSP_ERR_I, m_fail;
	logic [7:0] CMD_I, FAULT_CODE_I;
	fbsh_desc_t DESC_I;
	logic [63:0] STROBE_BITS_I, NODE_CONFIGURED_I, POLL_ESTABLISHED_I, POLL_ACTIVE_I, STROBE_BITS_O, ONLINE_MAP_O;
	logic [15:0] STATUS_O, FAULT_WORD0_O, FAULT_WORD1_O, MAIL_ADDR_O, MAIL_WDATA_O, MAIL_RDATA_I, FAULT_DATA_I;
	logic [15:0] XM_TX_BYTES_O, XM_RD_DATA_O, XM_RSP_DATA_I, XM_RSP_BYTES_I;
	logic [5:0] FAULT_NODE_I, XM_NODE_O;
	logic [15:0] PLC_REG_COUNT_I = 16'd200;
	logic [5:0] XM_RD_IDX_I = 6'h00;
	logic [1:0] lat, fm;
	int seed = 51;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	// ----
	// design, host store and clock
	// ----
	fbsh_host_if #(.POLL_CYCLES(20), .TIMEOUT_MS(5)) dut (.*);
	assign m_fail = (fm == 2'h1 && !MAIL_WE_O) || (fm == 2'h2 && MAIL_WE_O);
	fbsh_plc_model pm (.clk_i(CLOCK_I), .req_i(MAIL_REQ_O), .we_i(MAIL_WE_O), .addr_i(MAIL_ADDR_O),
		.wdata_i(MAIL_WDATA_O), .lat_i(lat), .fail_i(m_fail), .ack_o(MAIL_ACK_I), .err_o(MAIL_ERR_I),
		.rdata_o(MAIL_RDATA_I));
	initial begin
		CLOCK_I = 1'b0;
		forever #5 CLOCK_I = ~CLOCK_I;
	end
	always @(posedge CLOCK_I) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_sim();
		end
	end
	// ----
	// shared tasks
	// ----
	task chk(input string n, input logic [63:0] s, input logic [63:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_sim();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task net(input logic [63:0] e, input logic [63:0] a, input logic [63:0] c);
		@(posedge CLOCK_I);
		POLL_ESTABLISHED_I <= e;
		POLL_ACTIVE_I <= a;
		NODE_CONFIGURED_I <= c;
		STROBE_BITS_I <= {$random(seed), $random(seed)};
		repeat (8) @(negedge CLOCK_I);
		chk("online", ONLINE_MAP_O, e & a);
		chk("offline", STATUS_O[0], |(c & ~(e & a)));
		chk("strobe", STROBE_BITS_O, STROBE_BITS_I);
		$display("test net done");
	endtask
	task respond(input int rm, input logic [15:0] w0, input logic [15:0] w1);
		@(posedge CLOCK_I);
		if (rm == 1)
			XM_RSP_ERR_I <= 1'b1;
		if (rm == 0) begin
			XM_RSP_VALID_I <= 1'b1;
			XM_RSP_DATA_I <= w0;
			@(posedge CLOCK_I);
			XM_RSP_DATA_I <= w1;
			@(posedge CLOCK_I);
			XM_RSP_VALID_I <= 1'b0;
			XM_RSP_DATA_I <= ~w1;
			XM_RSP_DONE_I <= 1'b1;
			XM_RSP_BYTES_I <= 16'd4;
		end
		@(posedge CLOCK_I);
		XM_RSP_ERR_I <= 1'b0;
		XM_RSP_DONE_I <= 1'b0;
	endtask
	task xact(input int k);
		logic [7:0] node;
		logic [15:0] len, alloc, rw0, rw1;
		int rm, e, i;
		node = 8'd3;
		len = 16'd3;
		alloc = 16'd20;
		rm = 0;
		fm = 2'h0;
		case (k)
			1: len = 16'd0;
			2: fm = 2'h1;
			3: node = 8'd70;
			4: node = 8'd9;
			5: node = 8'd5;
			6: rm = 2;
			7: rm = 1;
			8: alloc = 16'd4;
			9: fm = 2'h2;
			default: ;
		endcase
		e = 0;
		if (len == 0 || 9 + (len + 1) / 2 > 200 || 49 + (alloc + 1) / 2 > 200)
			e = 3;
		else if (fm == 2'h1)
			e = 4;
		else if (node > 63)
			e = 5;
		else if (!NODE_CONFIGURED_I[node])
			e = 6;
		else if (!(POLL_ESTABLISHED_I[node] && POLL_ACTIVE_I[node]))
			e = 7;
		else if (rm == 2)
			e = 8;
		else if (rm == 1)
			e = 9;
		else if (alloc < 6)
			e = 10;
		else if (fm == 2'h2)
			e = 11;
		rw0 = $random(seed);
		rw1 = $random(seed);
		pm.mem[10] = {8'h0e, node};
		pm.mem[11] = 16'h0001;
		pm.mem[50] = 16'h0000;
		@(posedge CLOCK_I);
		DESC_I <= {16'd10, len, 16'd50, alloc};
		lat <= 2'(k % 3);
		CMD_I[1] <= 1'b1;
		for (i = 0; i < 40 && STATUS_O[2] !== 1'b0; i++)
			@(negedge CLOCK_I);
		for (i = 0; i < 3000 && STATUS_O[2] !== 1'b1; i++) begin
			@(negedge CLOCK_I);
			if (XM_REQ_O === 1'b1) begin
				chk("node", XM_NODE_O, node[5:0]);
				chk("txbytes", XM_TX_BYTES_O, len);
				chk("txword", XM_RD_DATA_O, pm.mem[10]);
				respond(rm, rw0, rw1);
			end
		end
		chk("status", STATUS_O[11:2], 10'h1 | (e > 0 ? 10'h1 << (e - 2) : 10'h0));
		if (e == 0) begin
			chk("rx0", pm.mem[50], 16'd4);
			chk("rx1", pm.mem[51], rw0);
			chk("rx2", pm.mem[52], rw1);
		end
		@(posedge CLOCK_I);
		CMD_I[1] <= 1'b0;
		repeat (30) @(posedge CLOCK_I);
		$display("test xact %0d done", k);
	endtask
	task show(input int b, input logic [15:0] w0, input logic [15:0] w1);
		@(posedge CLOCK_I);
		CMD_I[b] <= 1'b1;
		repeat (6) @(posedge CLOCK_I);
		CMD_I[b] <= 1'b0;
		repeat (6) @(negedge CLOCK_I);
		chk("fault0", FAULT_WORD0_O, w0);
		chk("fault1", FAULT_WORD1_O, w1);
		$display("test show %0d done", b);
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		{CMD_I, DESC_I, STROBE_BITS_I, NODE_CONFIGURED_I, POLL_ESTABLISHED_I, POLL_ACTIVE_I, FAULT_LOG_I,
			FAULT_NODE_I, FAULT_CODE_I, FAULT_DATA_I, XM_RSP_VALID_I, XM_RSP_DATA_I, XM_RSP_DONE_I,
			XM_RSP_BYTES_I, XM_RSP_ERR_I, RST_N_I, fm, lat} = '0;
		repeat (10) @(posedge CLOCK_I);
		RST_N_I <= 1'b1;
		@(posedge CLOCK_I);
		CMD_I[0] <= 1'b1;
		repeat (8) @(negedge CLOCK_I);
		chk("halted", STATUS_O[1], 1'b1);
		chk("scan", SCAN_ENABLE_O, 1'b0);
		@(posedge CLOCK_I);
		CMD_I[0] <= 1'b0;
		repeat (8) @(negedge CLOCK_I);
		chk("halted", STATUS_O[1], 1'b0);
		chk("scan", SCAN_ENABLE_O, 1'b1);
		$display("test halt done");
		net({$random(seed), $random(seed)}, {$random(seed), $random(seed)}, '1);
		net('1, '1, '1);
		net(~64'h220, ~64'h220, ~64'h200);
		for (int k = 0; k < 11; k++)
			xact(k);
		@(posedge CLOCK_I);
		FAULT_LOG_I <= 1'b1;
		FAULT_NODE_I <= 6'd20;
		FAULT_CODE_I <= 8'h03;
		FAULT_DATA_I <= 16'h0a0b;
		@(posedge CLOCK_I);
		FAULT_NODE_I <= 6'd7;
		FAULT_CODE_I <= 8'h01;
		FAULT_DATA_I <= 16'd1234;
		@(posedge CLOCK_I);
		FAULT_LOG_I <= 1'b0;
		show(2, 16'h0107, 16'd1234);
		show(3, 16'h0314, 16'h0a0b);
		show(3, 16'h0107, 16'd1234);
		show(4, 16'h0000, 16'h0000);
		show(2, 16'h0000, 16'h0000);
		end_sim();
	end
endmodule
